// ### rtl/pfs_pin_function_select.v
// Pin function select for port 3 pins 2..7, port 5 pins 6..7 and port 4.
// Assumes one clock, peripherals on that clock, and a pad ring that
// resolves pin level from pinOut and pinOutEnN outside this module.
`timescale 1ns/10ps
`default_nettype none
`include "pfs_regs.vh"

module pfs_pin_function_select (
  // Clock, reset, clock enable.
  input  wire        clk,
  input  wire        rst,
  input  wire        clkEn,
  // Register port.
  input  wire [15:0] regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWrStb,
  input  wire        regRdStb,
  output reg  [7:0]  regRdData,
  // Package pins, index order P3.2..P3.7, P5.6, P5.7, P4.0..P4.7.
  input  wire [15:0] pinIn,
  output reg  [15:0] pinOut,
  output reg  [15:0] pinOutEnN,
  output reg  [15:0] pinAnalogFree,
  // General-purpose I/O logic.
  input  wire [15:0] gpioOut,
  input  wire [15:0] gpioOutEn,
  output reg  [15:0] gpioIn,
  // Counter array.
  input  wire        counterCh4Output,
  input  wire        counterCh5Output,
  // SPI unit.
  output reg         spiChipEnableN,
  input  wire        spiMosiOut,
  input  wire        spiMosiOutEn,
  output reg         spiMosiIn,
  input  wire        spiMisoOut,
  input  wire        spiMisoOutEn,
  output reg         spiMisoIn,
  input  wire        spiClockOut,
  input  wire        spiClockOutEn,
  output reg         spiClockIn,
  // CAN controller.
  output reg         canReceive,
  input  wire        canTransmit,
  output reg         pinInterrupt2En,
  output reg         pinInterrupt2Level,
  // CEC controller and wake-up.
  input  wire        cecDriveLow,
  output reg         cecLineIn,
  output reg         stopWakeup,
  // Second I2C slave controller.
  input  wire        secondSlaveDataDriveLow,
  output reg         secondSlaveDataIn,
  input  wire        secondSlaveClockDriveLow,
  output reg         secondSlaveClockIn,
  // Wide pulse controller.
  input  wire        widePulseOutput
);

  // ****************************************************************
  // Register storage and address decode
  // ****************************************************************

  // Address table, entry i at bits [16*i +: 16]; writable-mask table, entry i at bits [8*i +: 8].
  localparam [255:0] ADDR_TABLE = {
    `PFS_PORT4_PIN7_FUNCTION_SELECT, `PFS_PORT4_PIN6_FUNCTION_SELECT,
    `PFS_PORT4_PIN5_FUNCTION_SELECT, `PFS_PORT4_PIN4_FUNCTION_SELECT,
    `PFS_PORT4_PIN3_FUNCTION_SELECT, `PFS_PORT4_PIN2_FUNCTION_SELECT,
    `PFS_PORT4_PIN1_FUNCTION_SELECT, `PFS_PORT4_PIN0_FUNCTION_SELECT,
    `PFS_PORT5_PIN7_FUNCTION_SELECT, `PFS_PORT5_PIN6_FUNCTION_SELECT,
    `PFS_PORT3_PIN7_FUNCTION_SELECT, `PFS_PORT3_PIN6_FUNCTION_SELECT,
    `PFS_PORT3_PIN5_FUNCTION_SELECT, `PFS_PORT3_PIN4_FUNCTION_SELECT,
    `PFS_PORT3_PIN3_FUNCTION_SELECT, `PFS_PORT3_PIN2_FUNCTION_SELECT};

  // Undefined bits are dropped at write time rather than masked at read
  // time, so a stored value never holds a bit that a route could see.
  localparam [127:0] MASK_TABLE = {
    `PFS_MASK_PORT4_PIN7, `PFS_MASK_IO_ONLY, `PFS_MASK_IO_ONLY,
    `PFS_MASK_IO_ONLY, `PFS_MASK_ONE_FUNCTION, `PFS_MASK_IO_ONLY,
    `PFS_MASK_ONE_FUNCTION, `PFS_MASK_PORT4_PIN0, `PFS_MASK_IO_ONLY,
    `PFS_MASK_IO_ONLY, `PFS_MASK_ONE_FUNCTION, `PFS_MASK_ONE_FUNCTION,
    `PFS_MASK_ONE_FUNCTION, `PFS_MASK_ONE_FUNCTION,
    `PFS_MASK_ONE_FUNCTION, `PFS_MASK_ONE_FUNCTION};

  reg  [7:0]  funcSel_reg [0:`PFS_PIN_COUNT-1];
  wire [15:0] addrHit;
  wire [15:0] ioSel;

  // One select register per pin; only defined bits are stored.
  // A low clkEn holds every register; reset still acts, so a frozen
  // block can always be brought back to a known state.
  genvar i;
  generate
    for (i = 0; i < `PFS_PIN_COUNT; i = i + 1) begin : gSel
      assign addrHit[i] = (regAddr == ADDR_TABLE[16*i +: 16]);
      assign ioSel[i] = funcSel_reg[i][`PFS_GENERAL_IO_SELECT];
      always @(posedge clk) begin
        if (rst) begin
          funcSel_reg[i] <= `PFS_RESET_VALUE;
        end else if (clkEn && regWrStb && addrHit[i]) begin
          funcSel_reg[i] <= regWrData & MASK_TABLE[8*i +: 8];
        end
      end
    end
  endgenerate

  // Read decode: one compare per register, first match wins. An address
  // outside the table falls through to zero, so software probing a hole
  // never sees stale data from a neighbour.
  reg [7:0] rdWord;
  always @* begin
    if (regAddr == `PFS_PORT3_PIN2_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P3_2];
    end else if (regAddr == `PFS_PORT3_PIN3_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P3_3];
    end else if (regAddr == `PFS_PORT3_PIN4_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P3_4];
    end else if (regAddr == `PFS_PORT3_PIN5_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P3_5];
    end else if (regAddr == `PFS_PORT3_PIN6_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P3_6];
    end else if (regAddr == `PFS_PORT3_PIN7_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P3_7];
    end else if (regAddr == `PFS_PORT5_PIN6_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P5_6];
    end else if (regAddr == `PFS_PORT5_PIN7_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P5_7];
    end else if (regAddr == `PFS_PORT4_PIN0_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P4_0];
    end else if (regAddr == `PFS_PORT4_PIN1_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P4_1];
    end else if (regAddr == `PFS_PORT4_PIN2_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P4_2];
    end else if (regAddr == `PFS_PORT4_PIN3_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P4_3];
    end else if (regAddr == `PFS_PORT4_PIN4_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P4_4];
    end else if (regAddr == `PFS_PORT4_PIN5_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P4_5];
    end else if (regAddr == `PFS_PORT4_PIN6_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P4_6];
    end else if (regAddr == `PFS_PORT4_PIN7_FUNCTION_SELECT) begin
      rdWord = funcSel_reg[`PFS_P4_7];
    end else begin
      rdWord = 8'h00;
    end
  end

  // Read data stands only in the cycle after the strobe; an unmapped
  // address returns zero rather than stale data.
  always @(posedge clk) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (clkEn) begin
      if (regRdStb) begin
        regRdData <= rdWord;
      end else begin
        regRdData <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // Pin input synchronisers
  // ****************************************************************

  // Pins are asynchronous; nothing but the second stage reads the first.
  // Reset value is the idle-high level of pulled-up pins, so no false
  // falling edge reaches a peripheral in the first cycles after reset.
  reg [15:0] pinMeta_reg;
  reg [15:0] pinSync_reg;
  always @(posedge clk) begin
    if (rst) begin
      pinMeta_reg <= 16'hFFFF;
      pinSync_reg <= 16'hFFFF;
    end else if (clkEn) begin
      pinMeta_reg <= pinIn;
      pinSync_reg <= pinMeta_reg;
    end
  end

  // ****************************************************************
  // Output routing
  // ****************************************************************

  wire [7:0] selP40 = funcSel_reg[`PFS_P4_0];
  wire [7:0] selP47 = funcSel_reg[`PFS_P4_7];
  wire altP32 = funcSel_reg[`PFS_P3_2][`PFS_ALT_FUNCTION_SELECT];
  wire altP33 = funcSel_reg[`PFS_P3_3][`PFS_ALT_FUNCTION_SELECT];
  wire altP34 = funcSel_reg[`PFS_P3_4][`PFS_ALT_FUNCTION_SELECT];
  wire altP35 = funcSel_reg[`PFS_P3_5][`PFS_ALT_FUNCTION_SELECT];
  wire altP36 = funcSel_reg[`PFS_P3_6][`PFS_ALT_FUNCTION_SELECT];
  wire altP37 = funcSel_reg[`PFS_P3_7][`PFS_ALT_FUNCTION_SELECT];
  wire altP41 = funcSel_reg[`PFS_P4_1][`PFS_ALT_FUNCTION_SELECT];
  wire altP43 = funcSel_reg[`PFS_P4_3][`PFS_ALT_FUNCTION_SELECT];
  wire cecSel = selP40[`PFS_CEC_LINE_SELECT];
  wire cecWakeSel = selP40[`PFS_CEC_LOW_WAKEUP_SELECT];
  wire canRxSel = selP40[`PFS_CAN_RECEIVE_SELECT];
  wire pwmSel = selP47[`PFS_WIDE_PULSE_OUT_SELECT];
  wire canTxSel = selP47[`PFS_CAN_TRANSMIT_SELECT];

  // Next pin drive. General I/O wins over any alternate bit so that a
  // register broken by two set bits still behaves predictably; among
  // alternates the lowest bit wins. Open-drain lines only pull low; the
  // high level comes from the board, so no shared wire is ever fought over.
  reg [15:0] pinOut_next;
  reg [15:0] pinOutEnN_next;
  reg [15:0] pinAnalogFree_next;
  integer    p;
  always @* begin
    pinOut_next        = 16'h0000;
    pinOutEnN_next     = 16'hFFFF;
    pinAnalogFree_next = 16'h0000;
    for (p = 0; p < `PFS_PIN_COUNT; p = p + 1) begin
      if (ioSel[p]) begin
        pinOut_next[p]    = gpioOut[p];
        pinOutEnN_next[p] = ~gpioOutEn[p];
      end else if (funcSel_reg[p] == 8'h00) begin
        pinAnalogFree_next[p] = 1'b1;
      end
    end
    if (!ioSel[`PFS_P3_2] && altP32) begin
      pinOut_next[`PFS_P3_2]    = counterCh4Output;
      pinOutEnN_next[`PFS_P3_2] = 1'b0;
    end
    if (!ioSel[`PFS_P3_3] && altP33) begin
      pinOut_next[`PFS_P3_3]    = counterCh5Output;
      pinOutEnN_next[`PFS_P3_3] = 1'b0;
    end
    if (!ioSel[`PFS_P3_5] && altP35) begin
      pinOut_next[`PFS_P3_5]    = spiMosiOut;
      pinOutEnN_next[`PFS_P3_5] = ~spiMosiOutEn;
    end
    if (!ioSel[`PFS_P3_6] && altP36) begin
      pinOut_next[`PFS_P3_6]    = spiMisoOut;
      pinOutEnN_next[`PFS_P3_6] = ~spiMisoOutEn;
    end
    if (!ioSel[`PFS_P3_7] && altP37) begin
      pinOut_next[`PFS_P3_7]    = spiClockOut;
      pinOutEnN_next[`PFS_P3_7] = ~spiClockOutEn;
    end
    if (!ioSel[`PFS_P4_0] && cecSel) begin
      pinOut_next[`PFS_P4_0]    = 1'b0;
      pinOutEnN_next[`PFS_P4_0] = ~cecDriveLow;
    end
    if (!ioSel[`PFS_P4_1] && altP41) begin
      pinOut_next[`PFS_P4_1]    = 1'b0;
      pinOutEnN_next[`PFS_P4_1] = ~secondSlaveDataDriveLow;
    end
    if (!ioSel[`PFS_P4_3] && altP43) begin
      pinOut_next[`PFS_P4_3]    = 1'b0;
      pinOutEnN_next[`PFS_P4_3] = ~secondSlaveClockDriveLow;
    end
    if (!ioSel[`PFS_P4_7] && pwmSel) begin
      pinOut_next[`PFS_P4_7]    = widePulseOutput;
      pinOutEnN_next[`PFS_P4_7] = 1'b0;
    end else if (!ioSel[`PFS_P4_7] && canTxSel) begin
      pinOut_next[`PFS_P4_7]    = canTransmit;
      pinOutEnN_next[`PFS_P4_7] = 1'b0;
    end
  end

  // Registered pin drive; costs one cycle but keeps pads glitch free.
  always @(posedge clk) begin
    if (rst) begin
      pinOut        <= 16'h0000;
      pinOutEnN     <= 16'hFFFF;
      pinAnalogFree <= 16'hFFFF;
    end else if (clkEn) begin
      pinOut        <= pinOut_next;
      pinOutEnN     <= pinOutEnN_next;
      pinAnalogFree <= pinAnalogFree_next;
    end
  end

  // ****************************************************************
  // Input routing to peripherals
  // ****************************************************************

  // An unselected input other than pinInterrupt2Level, which always follows P4.0, shows its idle level: high for active-low
  // enables, recessive bus levels and open-drain lines, so a peripheral
  // never sees a false start from a pin it does not own.
  // Limitation: a pin reaches its peripheral three edges late (two
  // synchroniser stages and the output flop). The wake request is a
  // level, not a pulse: it stands while the line is low, so a wake
  // controller that samples late still sees it.
  wire cecLow = !pinSync_reg[`PFS_P4_0];
  always @(posedge clk) begin
    if (rst) begin
      gpioIn             <= 16'h0000;
      spiChipEnableN     <= 1'b1;
      spiMosiIn          <= 1'b0;
      spiMisoIn          <= 1'b0;
      spiClockIn         <= 1'b0;
      canReceive         <= 1'b1;
      pinInterrupt2En    <= 1'b0;
      pinInterrupt2Level <= 1'b1;
      cecLineIn          <= 1'b1;
      stopWakeup         <= 1'b0;
      secondSlaveDataIn  <= 1'b1;
      secondSlaveClockIn <= 1'b1;
    end else if (clkEn) begin
      gpioIn <= pinSync_reg & ioSel;
      spiChipEnableN <= altP34 ? pinSync_reg[`PFS_P3_4] : 1'b1;
      spiMosiIn <= altP35 & pinSync_reg[`PFS_P3_5];
      spiMisoIn <= altP36 & pinSync_reg[`PFS_P3_6];
      spiClockIn <= altP37 & pinSync_reg[`PFS_P3_7];
      canReceive <= canRxSel ? pinSync_reg[`PFS_P4_0] : 1'b1;
      pinInterrupt2En <= canRxSel;
      pinInterrupt2Level <= pinSync_reg[`PFS_P4_0];
      cecLineIn <= cecSel ? pinSync_reg[`PFS_P4_0] : 1'b1;
      stopWakeup <= (cecWakeSel | cecSel) & cecLow;
      secondSlaveDataIn <= altP41 ? pinSync_reg[`PFS_P4_1] : 1'b1;
      secondSlaveClockIn <= altP43 ? pinSync_reg[`PFS_P4_3] : 1'b1;
    end
  end

endmodule // pfs_pin_function_select

`default_nettype wire

// ### rtl/pfs_regs.vh
// Constants of the pin function select block: register addresses,
// writable-bit masks, field positions and reset value.
// Assumes inclusion by bare name from the design files of this block.
`ifndef PFS_REGS_VH
`define PFS_REGS_VH

// ****************************************************************
// Register addresses (byte addresses on the 16-bit register port)
// ****************************************************************
`define PFS_PORT3_PIN2_FUNCTION_SELECT 16'hA07A
`define PFS_PORT3_PIN3_FUNCTION_SELECT 16'hA07B
`define PFS_PORT3_PIN4_FUNCTION_SELECT 16'hA07C
`define PFS_PORT3_PIN5_FUNCTION_SELECT 16'hA07D
`define PFS_PORT3_PIN6_FUNCTION_SELECT 16'hA07E
`define PFS_PORT3_PIN7_FUNCTION_SELECT 16'hA07F
`define PFS_PORT5_PIN6_FUNCTION_SELECT 16'hA0BE
`define PFS_PORT5_PIN7_FUNCTION_SELECT 16'hA0BF
`define PFS_PORT4_PIN0_FUNCTION_SELECT 16'hA0D0
`define PFS_PORT4_PIN1_FUNCTION_SELECT 16'hA0D1
`define PFS_PORT4_PIN2_FUNCTION_SELECT 16'hA0D2
`define PFS_PORT4_PIN3_FUNCTION_SELECT 16'hA0D3
`define PFS_PORT4_PIN4_FUNCTION_SELECT 16'hA0D4
`define PFS_PORT4_PIN5_FUNCTION_SELECT 16'hA0D5
`define PFS_PORT4_PIN6_FUNCTION_SELECT 16'hA0D6
`define PFS_PORT4_PIN7_FUNCTION_SELECT 16'hA0D7

// ****************************************************************
// Bits that hold a value; all others read as zero
// ****************************************************************
`define PFS_MASK_ONE_FUNCTION 8'h03
`define PFS_MASK_IO_ONLY      8'h01
`define PFS_MASK_PORT4_PIN0   8'h0F
`define PFS_MASK_PORT4_PIN7   8'h07

// ****************************************************************
// Field positions and reset value
// ****************************************************************
`define PFS_GENERAL_IO_SELECT          0
`define PFS_ALT_FUNCTION_SELECT        1
`define PFS_CEC_LINE_SELECT            1
`define PFS_CEC_LOW_WAKEUP_SELECT      2
`define PFS_CAN_RECEIVE_SELECT         3
`define PFS_WIDE_PULSE_OUT_SELECT      1
`define PFS_CAN_TRANSMIT_SELECT        2
`define PFS_RESET_VALUE                8'h00

// ****************************************************************
// Pin count and pin indexes inside the block
// ****************************************************************
`define PFS_PIN_COUNT 16
`define PFS_P3_2      0
`define PFS_P3_3      1
`define PFS_P3_4      2
`define PFS_P3_5      3
`define PFS_P3_6      4
`define PFS_P3_7      5
`define PFS_P5_6      6
`define PFS_P5_7      7
`define PFS_P4_0      8
`define PFS_P4_1      9
`define PFS_P4_2      10
`define PFS_P4_3      11
`define PFS_P4_4      12
`define PFS_P4_5      13
`define PFS_P4_6      14
`define PFS_P4_7      15

`endif

// ### dv/pfs_pin_function_select_sva.sv
// Checker of the pin function select block: register port and pin routing.
// Assumes it sees only the top ports; the bench holds clkEn high.
`timescale 1ns/10ps
`default_nettype none
`include "pfs_regs.vh"

module pfs_pin_function_select_sva (
  // Clock, reset, clock enable.
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        clkEn,
  // Register port.
  input wire logic [15:0] regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrStb,
  input wire logic        regRdStb,
  input wire logic [7:0]  regRdData,
  // Pins and peripherals.
  input wire logic [15:0] pinIn,
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOutEnN,
  input wire logic [15:0] pinAnalogFree,
  input wire logic        canTransmit,
  input wire logic        widePulseOutput,
  input wire logic        canReceive,
  input wire logic        pinInterrupt2En,
  input wire logic        stopWakeup
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Shadows of the P4.0 and P4.7 selects, so no design internals are needed.
  logic [3:0] p40Reg;
  logic [2:0] p47Reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      p40Reg <= 4'h0;
      p47Reg <= 3'h0;
    end else if (clkEn && regWrStb) begin
      if (regAddr == `PFS_PORT4_PIN0_FUNCTION_SELECT) p40Reg <= regWrData[3:0];
      if (regAddr == `PFS_PORT4_PIN7_FUNCTION_SELECT) p47Reg <= regWrData[2:0];
    end
  end

  sequence wrP47;
    regWrStb && regAddr == `PFS_PORT4_PIN7_FUNCTION_SELECT;
  endsequence
  sequence rdP47;
    regRdStb && !regWrStb && regAddr == `PFS_PORT4_PIN7_FUNCTION_SELECT;
  endsequence

  chk_read_back: assert property (wrP47 ##1 !regWrStb ##1 rdP47 |=>
    regRdData == ($past(regWrData, 3) & `PFS_MASK_PORT4_PIN7)) else $error("P4.7 readback wrong");
  chk_read_idle: assert property (clkEn && !regRdStb |=> regRdData == 8'h00)
    else $error("read data not zero outside a read");
  chk_pwm_drive: assert property (p47Reg == 3'h2 |=>
    !pinOutEnN[15] && pinOut[15] == $past(widePulseOutput)) else $error("P4.7 not from PWM");
  chk_cantx_drive: assert property (p47Reg == 3'h4 |=>
    !pinOutEnN[15] && pinOut[15] == $past(canTransmit)) else $error("P4.7 not from CAN");
  chk_idle_free: assert property (p47Reg == 3'h0 [*2] |->
    pinOutEnN[15] && pinAnalogFree[15]) else $error("P4.7 driven with no select");
  chk_irq2_enable: assert property ($stable(p40Reg[3]) |->
    pinInterrupt2En == p40Reg[3]) else $error("interrupt 2 enable wrong");
  chk_can_rx: assert property ((p40Reg[3] && !pinIn[8]) [*4] |-> !canReceive)
    else $error("CAN receive not following pin");
  chk_wake_low: assert property ((p40Reg[2:1] != 2'b00 && !pinIn[8]) [*4] |->
    stopWakeup) else $error("no wake on low pin");
  chk_wake_quiet: assert property (p40Reg[2:1] == 2'b00 [*2] |-> !stopWakeup)
    else $error("wake with wake selects clear");
endmodule  // pfs_pin_function_select_sva

bind pfs_pin_function_select pfs_pin_function_select_sva u_sva (
  .clk, .rst, .clkEn, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .pinIn,
  .pinOut, .pinOutEnN, .pinAnalogFree, .canTransmit, .widePulseOutput, .canReceive,
  .pinInterrupt2En, .stopWakeup
);
`default_nettype wire

// ### dv/pfs_periph_model.sv
// Model of the on-chip peripherals and of the board around the pins.
// Assumes the bench ties each bit of pat to one or two peripheral outputs.
`timescale 1ns/10ps
`default_nettype none

module pfs_periph_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Level the board puts on each pin; high stands for a pull-up.
  input  wire logic [15:0] extLevel,
  // Block side of the pads.
  input  wire logic [15:0] pinOut,
  input  wire logic [15:0] pinOutEnN,
  output logic      [15:0] pinIn,
  // Peripheral output levels, one bit per source or pair of sources.
  output logic      [7:0]  pat
);
  // Sources keep changing, so a stale or wrong route rarely matches by luck.
  always_ff @(posedge clk) begin
    if (rst) begin
      pat <= 8'h5a;
    end else begin
      pat <= pat + 8'h3b;
    end
  end

  // A released pin shows the board level; a driven low wins like open drain.
  assign pinIn = extLevel & (pinOutEnN | pinOut);
endmodule  // pfs_periph_model
`default_nettype wire

// ### dv/test_port_pin_function_select.sv
// Self-checking bench of the pin function select block.
// Assumes the design, its constants header, the peripheral model and the checker.
`timescale 1ns/10ps
`default_nettype none
`include "pfs_regs.vh"

module test_port_pin_function_select;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrStb = 1'b0;
  logic        regRdStb = 1'b0;
  logic [15:0] extLevel = 16'hFFFF;
  logic        outEn = 1'b1;
  logic [7:0]  patPrev = 8'h00;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cycles = 0;
  wire  [7:0]  regRdData, pat;
  wire  [15:0] pinIn, pinOut, pinOutEnN, pinAnalogFree, gpioIn;
  wire         spiMosiIn, spiMisoIn, spiClockIn;
  wire         spiChipEnableN, canReceive, pinInterrupt2En, pinInterrupt2Level;
  wire         cecLineIn, stopWakeup, secondSlaveDataIn, secondSlaveClockIn;

  // ****************************************************************
  // Clock, partner, design, hang limit
  // ****************************************************************
  always #5 clk = ~clk;
  always @(posedge clk) patPrev <= pat;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      print_verdict;
    end
  end
  pfs_periph_model model (.clk, .rst, .extLevel, .pinOut, .pinOutEnN, .pinIn, .pat);
  pfs_pin_function_select dut (
    .clk, .rst, .clkEn(1'b1), .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
    .pinIn, .pinOut, .pinOutEnN, .pinAnalogFree, .gpioOut({16{pat[7]}}),
    .gpioOutEn({16{outEn}}), .gpioIn, .counterCh4Output(pat[0]), .counterCh5Output(pat[1]),
    .spiChipEnableN, .spiMosiOut(pat[2]), .spiMosiOutEn(outEn), .spiMosiIn,
    .spiMisoOut(pat[3]), .spiMisoOutEn(outEn), .spiMisoIn, .spiClockOut(pat[4]),
    .spiClockOutEn(outEn), .spiClockIn, .canReceive, .canTransmit(pat[5]),
    .pinInterrupt2En, .pinInterrupt2Level, .cecDriveLow(pat[1]), .cecLineIn, .stopWakeup,
    .secondSlaveDataDriveLow(pat[2]), .secondSlaveDataIn,
    .secondSlaveClockDriveLow(pat[3]), .secondSlaveClockIn, .widePulseOutput(pat[6]));

  // ****************************************************************
  // Bus cycles and helpers
  // ****************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] addrOf(input int i);
    if (i < 6) return `PFS_PORT3_PIN2_FUNCTION_SELECT + 16'(i);
    if (i < 8) return `PFS_PORT5_PIN6_FUNCTION_SELECT + 16'(i - 6);
    return `PFS_PORT4_PIN0_FUNCTION_SELECT + 16'(i - 8);
  endfunction
  function automatic logic [7:0] maskOf(input int i);
    if (i == 8) return `PFS_MASK_PORT4_PIN0;
    if (i == 15) return `PFS_MASK_PORT4_PIN7;
    if (i < 6 || i == 9 || i == 11) return `PFS_MASK_ONE_FUNCTION;
    return `PFS_MASK_IO_ONLY;
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1 check(regRdData, exp);
  endtask
  // Five edges cover the two-flop synchroniser and output flop, with margin.
  task automatic drive(input int pin, input logic lvl);
    @(posedge clk);
    extLevel[pin] <= lvl;
    repeat (5) @(posedge clk);
    #1;
  endtask
  // Selects one source, then compares the pin with that source one edge back.
  task automatic route(input int pin, input logic [7:0] sel, input int src);
    wr(addrOf(pin), sel);
    repeat (2) @(posedge clk);
    #1 check(pinOutEnN[pin], 1'b0);
    check(pinOut[pin], patPrev[src]);
    @(posedge clk);
    #1 check(pinOut[pin], patPrev[src]);
    wr(addrOf(pin), 8'h00);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_masks;
    for (int i = 0; i < 16; i++) begin
      rd(addrOf(i), 8'h00);
      wr(addrOf(i), 8'hFF);
      rd(addrOf(i), maskOf(i));
      wr(addrOf(i), 8'h00);
    end
    wr(16'hA080, 8'hFF);
    rd(16'hA080, 8'h00);
    $display("t_masks done");
  endtask
  // One select bit at a time, as software must.
  task automatic t_route;
    route(0, 8'h02, 0);
    route(1, 8'h02, 1);
    route(3, 8'h02, 2);
    route(4, 8'h02, 3);
    route(5, 8'h02, 4);
    route(15, 8'h04, 5);
    route(15, 8'h02, 6);
    route(10, 8'h01, 7);
    repeat (2) @(posedge clk);
    #1 check(pinOutEnN, 16'hFFFF);
    check(pinAnalogFree, 16'hFFFF);
    $display("t_route done");
  endtask
  task automatic t_inputs;
    wr(addrOf(2), 8'h02);
    drive(2, 1'b0);
    check(spiChipEnableN, 1'b0);
    check(pinOutEnN[2], 1'b1);
    drive(2, 1'b1);
    check(spiChipEnableN, 1'b1);
    wr(addrOf(8), 8'h08);
    drive(8, 1'b0);
    check({canReceive, pinInterrupt2En, pinInterrupt2Level}, 3'b010);
    drive(8, 1'b1);
    check(canReceive, 1'b1);
    wr(addrOf(8), 8'h04);
    drive(8, 1'b0);
    check(stopWakeup, 1'b1);
    drive(8, 1'b1);
    check(stopWakeup, 1'b0);
    wr(addrOf(8), 8'h02);
    drive(8, 1'b1);
    check(pinOutEnN[8], !patPrev[1]);
    drive(8, 1'b0);
    check({stopWakeup, cecLineIn}, 2'b10);
    wr(addrOf(8), 8'h00);
    wr(addrOf(9), 8'h02);
    wr(addrOf(11), 8'h02);
    drive(9, 1'b0);
    check(secondSlaveDataIn, 1'b0);
    drive(11, 1'b0);
    check(secondSlaveClockIn, 1'b0);
    $display("t_inputs done");
  endtask
  // Released outputs: the board level reaches the SPI inputs and general I/O.
  task automatic t_levels;
    @(posedge clk);
    outEn <= 1'b0;
    wr(addrOf(3), 8'h02);
    wr(addrOf(4), 8'h02);
    wr(addrOf(5), 8'h02);
    wr(addrOf(12), 8'h01);
    drive(3, 1'b1);
    check({spiMosiIn, spiMisoIn, spiClockIn}, 3'b111);
    check(pinOutEnN[5:3], 3'b111);
    check(gpioIn, 16'h1000);
    drive(3, 1'b0);
    check(spiMosiIn, 1'b0);
    drive(12, 1'b0);
    check(gpioIn, 16'h0000);
    $display("t_levels done");
  endtask

  task automatic print_verdict;
    $display("Compared %0d, mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Reset for sixteen cycles, then run every scenario once.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_masks;
    t_route;
    t_inputs;
    t_levels;
    print_verdict;
  end
endmodule  // test_port_pin_function_select
`default_nettype wire
